// [shared/pfsel_pkg.sv]
// Purpose: constants for the port F upper pin function selector
// Assumes: 16-bit control registers on a plain strobe port
// Notes:   offsets are byte addresses of 16-bit registers
package pfsel_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int          ADDR_W      = 4;
  localparam int          DATA_W      = 16;
  localparam logic [3:0]  OFS_UPPER   = 4'h0;
  localparam logic [3:0]  OFS_LOWER   = 4'h2;
  localparam logic [3:0]  OFS_DIR     = 4'h4;
  localparam logic [3:0]  OFS_STAT    = 4'h6;

  // ****************************************************************
  // reset values and writable masks
  // ****************************************************************
  localparam logic [15:0] UPPER_RST   = 16'h0015;
  localparam logic [15:0] LOWER_RST   = 16'h5000;
  localparam logic [15:0] DIR_RST     = 16'h0000;
  localparam logic [15:0] UPPER_WMASK = 16'hd555;
  localparam logic [15:0] LOWER_WMASK = 16'h5d55;

  // ****************************************************************
  // field positions in the upper control register
  // ****************************************************************
  localparam int          BIT_CK_FLOAT = 15;
  localparam int          BIT_PIN15    = 14;
  localparam int          BIT_PIN14    = 12;
  localparam int          BIT_PIN13    = 10;
  localparam int          BIT_PIN12    = 8;
  localparam int          BIT_PIN11    = 6;
  localparam int          BIT_PIN10    = 4;
  localparam int          BIT_PIN9     = 2;
  localparam int          BIT_PIN8     = 0;
  localparam int          NPINS        = 8;
  // upper pins whose bus function is an input (pin15 request, pin8 wait)
  localparam logic [7:0]  FUNC_IS_IN   = 8'h81;

  // function or general I/O, decoded per pin
  function automatic logic pfsel_func_on(input logic sel, input logic expanded);
    return sel & expanded;
  endfunction

  function automatic logic pfsel_hit(input logic [3:0] addr, input logic [3:0] ofs);
    return addr == ofs;
  endfunction

endpackage

// [shared/pfsel_cfg_if.sv]
// Purpose: carries the stored configuration from register block to top
// Assumes: single clock domain
// Notes:   no logic inside
`timescale 1ns/1ps
`default_nettype none
interface pfsel_cfg_if;
  logic [15:0] upper;
  logic [15:0] lower;
  logic [15:0] dir;
  modport regs (output upper, output lower, output dir);
  modport user (input upper, input lower, input dir);
endinterface
`default_nettype wire

// [verilog/pfsel_ctrl_regs.sv]
// Purpose: upper, lower and direction registers of port F
// Assumes: hardware standby is a synchronous level from the power logic
// Notes:   watchdog resets do not reach sys_rst of this block
`timescale 1ns/1ps
`default_nettype none
module pfsel_ctrl_regs
  import pfsel_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // power states
  input  wire logic              hw_standby,
  input  wire logic              low_power_hold,
  // write port
  input  wire logic              reg_wr,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wr_data,
  // stored values
  pfsel_cfg_if.regs              cfg
);

  logic wr_ok;
  // sleep and software standby freeze the contents
  assign wr_ok = reg_wr & ~low_power_hold;

  // ****************************************************************
  // upper control register
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg.upper <= UPPER_RST;
    end else if (hw_standby) begin
      cfg.upper <= UPPER_RST;
    end else if (wr_ok && pfsel_hit(reg_addr, OFS_UPPER)) begin
      cfg.upper <= reg_wr_data & UPPER_WMASK;
    end
  end

  // ****************************************************************
  // lower control register
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg.lower <= LOWER_RST;
    end else if (hw_standby) begin
      cfg.lower <= LOWER_RST;
    end else if (wr_ok && pfsel_hit(reg_addr, OFS_LOWER)) begin
      cfg.lower <= reg_wr_data & LOWER_WMASK;
    end
  end

  // ****************************************************************
  // direction register
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg.dir <= DIR_RST;
    end else if (hw_standby) begin
      cfg.dir <= DIR_RST;
    end else if (wr_ok && pfsel_hit(reg_addr, OFS_DIR)) begin
      cfg.dir <= reg_wr_data;
    end
  end

endmodule
`default_nettype wire

// [verilog/pfsel_pin_cell.sv]
// Purpose: one multiplexed pin, general I/O or bus function
// Assumes: mode is static while the pin is in use
// Notes:   purely combinational; the top registers the results
`timescale 1ns/1ps
`default_nettype none
module pfsel_pin_cell
  import pfsel_pkg::*;
#(
  parameter bit FUNC_IN = 1'b0
) (
  // selection
  input  wire logic sel,
  input  wire logic expanded,
  input  wire logic dir,
  // data sources
  input  wire logic gp_do,
  input  wire logic fn_do,
  // pad side
  output logic      pad_o,
  output logic      pad_oe,
  output logic      func_on
);

  always_comb begin
    func_on = pfsel_func_on(sel, expanded);
    if (func_on) begin
      pad_o  = FUNC_IN ? 1'b0 : fn_do;
      pad_oe = ~FUNC_IN;
    end else begin
      pad_o  = gp_do;
      pad_oe = dir;
    end
  end

endmodule
`default_nettype wire

// [verilog/pfsel_top.sv]
// Purpose: pin function select for the upper eight port F pins and CK
// Assumes: inputs synchronous to clk; operating mode static
// Notes:   every pad output passes through one register stage
`timescale 1ns/1ps
`default_nettype none
module pfsel_top
  import pfsel_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // power and mode
  input  wire logic              hw_standby,
  input  wire logic              low_power_hold,
  input  wire logic              mode_expanded,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wr_data,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rd_data,
  // upper pads, index 0 is pin 8
  input  wire logic [NPINS-1:0]  pad_in,
  output logic      [NPINS-1:0]  pad_out,
  output logic      [NPINS-1:0]  pad_oe,
  // clock pin
  input  wire logic              ck_src,
  output logic                   ck_pin_out,
  output logic                   ck_pin_oe,
  // general I/O data
  input  wire logic [NPINS-1:0]  gpio_out_data,
  output logic      [NPINS-1:0]  gpio_in_data,
  // bus controller, active low strobes
  input  wire logic              chip_select_zero_out_n,
  input  wire logic              chip_select_one_out_n,
  input  wire logic              chip_select_two_out_n,
  input  wire logic              chip_select_three_out_n,
  input  wire logic              read_strobe_n,
  input  wire logic              bus_ack_n,
  output logic                   bus_request_in_n,
  output logic                   wait_req_n,
  // lower half configuration
  output logic      [15:0]       lower_ctrl,
  output logic      [7:0]        lower_dir
);

  // ****************************************************************
  // registers
  // ****************************************************************
  pfsel_cfg_if cfg ();

  pfsel_ctrl_regs u_regs (
    .clk            (clk),
    .sys_rst        (sys_rst),
    .hw_standby     (hw_standby),
    .low_power_hold (low_power_hold),
    .reg_wr         (reg_wr),
    .reg_addr       (reg_addr),
    .reg_wr_data    (reg_wr_data),
    .cfg            (cfg.regs)
  );

  // ****************************************************************
  // pin multiplexers
  // ****************************************************************
  logic [NPINS-1:0] fn_drive;
  logic [NPINS-1:0] pad_o_nxt;
  logic [NPINS-1:0] pad_oe_nxt;
  logic [NPINS-1:0] func_on;
  logic [NPINS-1:0] sel_bits;

  // select bit of upper pin 8+i sits at bit 2*i
  assign sel_bits = {cfg.upper[BIT_PIN15], cfg.upper[BIT_PIN14],
                     cfg.upper[BIT_PIN13], cfg.upper[BIT_PIN12],
                     cfg.upper[BIT_PIN11], cfg.upper[BIT_PIN10],
                     cfg.upper[BIT_PIN9],  cfg.upper[BIT_PIN8]};

  // input functions have no drive; their slots are tied low
  assign fn_drive = {1'b0, bus_ack_n,
                     chip_select_three_out_n, chip_select_two_out_n,
                     chip_select_one_out_n, chip_select_zero_out_n,
                     read_strobe_n, 1'b0};

  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pin
      pfsel_pin_cell #(
        .FUNC_IN (FUNC_IS_IN[gi])
      ) u_cell (
        .sel      (sel_bits[gi]),
        .expanded (mode_expanded),
        .dir      (cfg.dir[NPINS+gi]),
        .gp_do    (gpio_out_data[gi]),
        .fn_do    (fn_drive[gi]),
        .pad_o    (pad_o_nxt[gi]),
        .pad_oe   (pad_oe_nxt[gi]),
        .func_on  (func_on[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // pad output stage
  // ****************************************************************
  // one register stage keeps pads glitch free at a cycle of latency
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pad_out <= '0;
      pad_oe  <= '0;
    end else begin
      pad_out <= pad_o_nxt;
      pad_oe  <= pad_oe_nxt;
    end
  end

  // ****************************************************************
  // function inputs back to the core
  // ****************************************************************
  // an unselected request or wait input reads inactive (high)
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_request_in_n <= 1'b1;
      wait_req_n       <= 1'b1;
      gpio_in_data     <= '0;
    end else begin
      bus_request_in_n <= func_on[7] ? pad_in[7] : 1'b1;
      wait_req_n       <= func_on[0] ? pad_in[0] : 1'b1;
      gpio_in_data     <= pad_in;
    end
  end

  // ****************************************************************
  // clock pin
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ck_pin_out <= 1'b0;
      ck_pin_oe  <= 1'b1;
    end else begin
      ck_pin_out <= ck_src;
      ck_pin_oe  <= ~cfg.upper[BIT_CK_FLOAT];
    end
  end

  // ****************************************************************
  // lower half outputs
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lower_ctrl <= LOWER_RST;
      lower_dir  <= DIR_RST[7:0];
    end else begin
      lower_ctrl <= cfg.lower;
      lower_dir  <= cfg.dir[7:0];
    end
  end

  // ****************************************************************
  // register read port
  // ****************************************************************
  logic [DATA_W-1:0] rd_mux;

  // status word: effective functions in the low byte, mode in bit 8
  always_comb begin
    rd_mux = '0;
    if (pfsel_hit(reg_addr, OFS_UPPER)) begin
      rd_mux = cfg.upper & UPPER_WMASK;
    end else if (pfsel_hit(reg_addr, OFS_LOWER)) begin
      rd_mux = cfg.lower;
    end else if (pfsel_hit(reg_addr, OFS_DIR)) begin
      rd_mux = cfg.dir;
    end else if (pfsel_hit(reg_addr, OFS_STAT)) begin
      rd_mux = {7'h00, mode_expanded, func_on};
    end
  end

  // read data stands in each cycle after reg_rd is high, zero otherwise
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rd_data <= '0;
    end else begin
      reg_rd_data <= reg_rd ? rd_mux : '0;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_wr_upper;
    reg_wr && pfsel_hit(reg_addr, OFS_UPPER) && !hw_standby && !low_power_hold;
  endsequence

  sequence s_rd_upper;
    reg_rd && pfsel_hit(reg_addr, OFS_UPPER);
  endsequence

  property p_upper_rw;
    s_wr_upper ##1 s_rd_upper |=> reg_rd_data == ($past(reg_wr_data, 2) & UPPER_WMASK);
  endproperty
  a_upper_rw: assert property (p_upper_rw) else $error("upper write not read back");

  property p_lower_out;
    hw_standby |=> ##1 lower_ctrl == LOWER_RST;
  endproperty
  a_lower_out: assert property (p_lower_out) else $error("lower control not reloaded");

  property p_standby_load;
    hw_standby |=> cfg.upper == UPPER_RST && cfg.lower == LOWER_RST && cfg.dir == DIR_RST;
  endproperty
  a_standby_load: assert property (p_standby_load) else $error("standby reload wrong");

  property p_hold;
    low_power_hold && !hw_standby |=> $stable(cfg.upper) && $stable(cfg.lower);
  endproperty
  a_hold: assert property (p_hold) else $error("registers changed in low power");

  property p_ck;
    ##1 ck_pin_oe == !$past(cfg.upper[BIT_CK_FLOAT]) && ck_pin_out == $past(ck_src);
  endproperty
  a_ck: assert property (p_ck) else $error("clock pin control wrong");

  property p_bus_request_in;
    mode_expanded && cfg.upper[BIT_PIN15] |=> !pad_oe[7] && bus_request_in_n == $past(pad_in[7]);
  endproperty
  a_bus_request_in: assert property (p_bus_request_in) else $error("bus request pin wrong");

  property p_back;
    mode_expanded && cfg.upper[BIT_PIN14] |=> pad_oe[6] && pad_out[6] == $past(bus_ack_n);
  endproperty
  a_back: assert property (p_back) else $error("bus acknowledge pin wrong");

  property p_cs3;
    mode_expanded && cfg.upper[BIT_PIN13] |=> pad_oe[5] && pad_out[5] == $past(chip_select_three_out_n);
  endproperty
  a_cs3: assert property (p_cs3) else $error("chip select 3 pin wrong");

  property p_cs2;
    mode_expanded && cfg.upper[BIT_PIN12] |=> pad_oe[4] && pad_out[4] == $past(chip_select_two_out_n);
  endproperty
  a_cs2: assert property (p_cs2) else $error("chip select 2 pin wrong");

  property p_cs1;
    mode_expanded && cfg.upper[BIT_PIN11] |=> pad_oe[3] && pad_out[3] == $past(chip_select_one_out_n);
  endproperty
  a_cs1: assert property (p_cs1) else $error("chip select 1 pin wrong");

  property p_cs0;
    mode_expanded && cfg.upper[BIT_PIN10] |=> pad_oe[2] && pad_out[2] == $past(chip_select_zero_out_n);
  endproperty
  a_cs0: assert property (p_cs0) else $error("chip select 0 pin wrong");

  property p_rd;
    mode_expanded && cfg.upper[BIT_PIN9] |=> pad_oe[1] && pad_out[1] == $past(read_strobe_n);
  endproperty
  a_rd: assert property (p_rd) else $error("read strobe pin wrong");

  property p_wait;
    mode_expanded && cfg.upper[BIT_PIN8] |=> !pad_oe[0] && wait_req_n == $past(pad_in[0]);
  endproperty
  a_wait: assert property (p_wait) else $error("wait pin wrong");

  property p_rsv;
    s_rd_upper |=> (reg_rd_data & ~UPPER_WMASK) == 16'h0000;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");

  property p_gpio;
    !mode_expanded |=> pad_oe == $past(cfg.dir[15:8]) && pad_out == $past(gpio_out_data);
  endproperty
  a_gpio: assert property (p_gpio) else $error("single-chip pins not general I/O");

endmodule
`default_nettype wire

// [test/pfsel_ext_bus_model.sv]
// Purpose: far side of the upper port F pads: memories and bus masters
// Assumes: pads driven by the block read back their own level
// Notes:   released pads carry bench levels or a level that flips each cycle
`timescale 1ns/1ps
`default_nettype none
module pfsel_ext_bus_model
  import pfsel_pkg::*;
(
  // clock
  input  wire logic             clk,
  // device pads
  input  wire logic [NPINS-1:0] pad_out,
  input  wire logic [NPINS-1:0] pad_oe,
  // levels the bench commands on released pads
  input  wire logic             ext_en,
  input  wire logic [NPINS-1:0] ext_val,
  output logic      [NPINS-1:0] pad_in
);
  // ****************************************************************
  // pad levels
  // ****************************************************************
  logic [NPINS-1:0] churn_r = 8'h5a;

  // an undriven pad with ext_en low must never look stable to the block
  always @(posedge clk) begin
    churn_r <= ~churn_r;
  end

  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      pad_in[i] = pad_oe[i] ? pad_out[i] : (ext_en ? ext_val[i] : churn_r[i]);
    end
  end
endmodule
`default_nettype wire

// [test/tb_port_f_upper_pin_function_select.sv]
// Purpose: self-checking bench for the upper port F pin selector
// Assumes: pad outputs settle one cycle after a register or input change
// Notes:   all inputs move by non-blocking assignment at the rising edge
`timescale 1ns/1ps
`default_nettype none
module tb_port_f_upper_pin_function_select
  import pfsel_pkg::*;
;
  // ****************************************************************
  // stimulus and wiring
  // ****************************************************************
  logic clk = 1'b0, sys_rst = 1'b1, hw_standby = 1'b0, low_power_hold = 1'b0;
  logic mode_expanded = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, ck_src = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wr_data = '0, reg_rd_data, lower_ctrl;
  logic [NPINS-1:0]  pad_in, pad_out, pad_oe, gpio_out_data = '0, gpio_in_data, lower_dir;
  logic [NPINS-1:0]  ext_val = '0;
  logic ext_en = 1'b1, ck_pin_out, ck_pin_oe, bus_request_in_n, wait_req_n;
  logic cs0_n = 1'b1, cs1_n = 1'b1, cs2_n = 1'b1, cs3_n = 1'b1, rd_n = 1'b1, ack_n = 1'b1;
  int   mismatches = 0;
  int   n_tests = 0;

  initial begin
    forever #5 clk = ~clk;
  end

  pfsel_top dut (
    .clk(clk), .sys_rst(sys_rst), .hw_standby(hw_standby),
    .low_power_hold(low_power_hold), .mode_expanded(mode_expanded),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rd_data(reg_rd_data), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .ck_src(ck_src), .ck_pin_out(ck_pin_out), .ck_pin_oe(ck_pin_oe),
    .gpio_out_data(gpio_out_data), .gpio_in_data(gpio_in_data),
    .chip_select_zero_out_n(cs0_n), .chip_select_one_out_n(cs1_n),
    .chip_select_two_out_n(cs2_n), .chip_select_three_out_n(cs3_n),
    .read_strobe_n(rd_n), .bus_ack_n(ack_n), .bus_request_in_n(bus_request_in_n),
    .wait_req_n(wait_req_n), .lower_ctrl(lower_ctrl), .lower_dir(lower_dir)
  );

  pfsel_ext_bus_model ext (
    .clk(clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in)
  );

  // ****************************************************************
  // bus cycles and comparisons
  // ****************************************************************
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read strobe rises at the caller's edge; data is taken 1 ns after the next edge, once the strobe has fallen
  task automatic rd_cmp(input string nm, input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] got;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 got = reg_rd_data;
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_reg(input string nm, input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    rd_cmp(nm, a, exp);
  endtask

  // write then read back with no idle cycle between the strobes
  task automatic wr_chk(input string nm, input logic [3:0] a, input logic [15:0] d,
                        input logic [15:0] exp);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    rd_cmp(nm, a, exp);
  endtask

  task automatic chk_pin(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // register write lands one edge later, pads one edge after that
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    settle();
    chk_pin("pad_oe", 8'h06, pad_oe);
    chk_pin("pad_out", 8'h06, pad_out);
    chk_pin("wait_req_n", 8'h00, {7'h0, wait_req_n});
    chk_pin("bus_request_in_n", 8'h01, {7'h0, bus_request_in_n});
    chk_pin("ck_pin_oe", 8'h01, {7'h0, ck_pin_oe});
    chk_pin("lower_ctrl", 8'h50, lower_ctrl[15:8]);
    chk_reg("upper", OFS_UPPER, 16'h0015);
    chk_reg("lower", OFS_LOWER, 16'h5000);
    chk_reg("dir", OFS_DIR, 16'h0000);
    chk_reg("unmapped", 4'h8, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_regs();
    wr_chk("upper", OFS_UPPER, 16'hffff, 16'hd555);
    wr(OFS_LOWER, 16'hffff);
    chk_reg("lower", OFS_LOWER, 16'h5d55);
    settle();
    chk_pin("lower_ctrl", 8'h5d, lower_ctrl[15:8]);
    wr(4'h8, 16'h1234);
    chk_reg("unmapped", 4'h8, 16'h0000);
    $display("test regs done");
  endtask

  task automatic t_func();
    logic p;
    wr(OFS_UPPER, 16'h5555);
    for (int k = 0; k < 2; k++) begin
      p = k[0];
      @(posedge clk);
      {ack_n, cs3_n, cs2_n, cs1_n, cs0_n, rd_n} <= p ? 6'h2a : 6'h15;
      ext_val <= p ? 8'h81 : 8'h00;
      settle();
      chk_pin("pad_oe", 8'h7e, pad_oe);
      chk_pin("pad_out", p ? 8'h54 : 8'h2a, pad_out);
      chk_pin("bus_request_in_n", {7'h0, p}, {7'h0, bus_request_in_n});
      chk_pin("wait_req_n", {7'h0, p}, {7'h0, wait_req_n});
    end
    chk_reg("status", OFS_STAT, 16'h01ff);
    $display("test functions done");
  endtask

  task automatic t_single();
    @(posedge clk);
    mode_expanded <= 1'b0;
    gpio_out_data <= 8'ha5;
    ext_val <= 8'h3c;
    wr(OFS_DIR, 16'h0f81);
    settle();
    chk_pin("pad_oe", 8'h0f, pad_oe);
    chk_pin("pad_out", 8'ha5, pad_out);
    chk_pin("gpio_in_data", 8'h35, gpio_in_data);
    chk_pin("lower_dir", 8'h81, lower_dir);
    chk_pin("wait_req_n", 8'h01, {7'h0, wait_req_n});
    chk_pin("bus_request_in_n", 8'h01, {7'h0, bus_request_in_n});
    chk_reg("status", OFS_STAT, 16'h0000);
    @(posedge clk);
    mode_expanded <= 1'b1;
    settle();
    chk_pin("pad_oe", 8'h7e, pad_oe);
    $display("test single chip done");
  endtask

  task automatic t_clock();
    @(posedge clk);
    ck_src <= 1'b1;
    wr(OFS_UPPER, 16'h8000);
    settle();
    chk_pin("ck_pin_oe", 8'h00, {7'h0, ck_pin_oe});
    wr(OFS_UPPER, 16'h0000);
    settle();
    chk_pin("ck_pin_oe", 8'h01, {7'h0, ck_pin_oe});
    chk_pin("ck_pin_out", 8'h01, {7'h0, ck_pin_out});
    chk_pin("pad_oe", 8'h0f, pad_oe);
    $display("test clock pin done");
  endtask

  task automatic t_power();
    wr(OFS_UPPER, 16'h0104);
    @(posedge clk);
    low_power_hold <= 1'b1;
    wr(OFS_UPPER, 16'h4000);
    @(posedge clk);
    low_power_hold <= 1'b0;
    chk_reg("upper", OFS_UPPER, 16'h0104);
    chk_reg("dir", OFS_DIR, 16'h0f81);
    @(posedge clk);
    hw_standby <= 1'b1;
    @(posedge clk);
    hw_standby <= 1'b0;
    chk_reg("upper", OFS_UPPER, 16'h0015);
    chk_reg("lower", OFS_LOWER, 16'h5000);
    chk_reg("dir", OFS_DIR, 16'h0000);
    $display("test power states done");
  endtask

  // ****************************************************************
  // run control
  // ****************************************************************
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    results();
  end

  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_regs();
    t_func();
    t_single();
    t_clock();
    t_power();
    results();
  end
endmodule
`default_nettype wire
